/* otc_defs.svh */
`ifndef OTC_DEFS_SVH
`define OTC_DEFS_SVH

// ==========================================================
// register map
`define OTC_ADDR_TRIM 8'h0B
`define OTC_ADDR_COEF 8'h0C
`define OTC_ADDR_CTRL 8'h0D

// ==========================================================
// field positions
`define OTC_TRIM_DIG_MSB 7
`define OTC_TRIM_DIG_LSB 6
`define OTC_TRIM_ANA_MSB 5
`define OTC_TRIM_ANA_LSB 0
`define OTC_COEF_MSB 6
`define OTC_CTRL_SENSE 7
`define OTC_CTRL_BATT_EN 6
`define OTC_CTRL_BATT_RATE 5
`define OTC_CTRL_GAIN_MSB 4

// ==========================================================
// reset values
`define OTC_TRIM_RESET 8'h00
`define OTC_COEF_RESET 8'h00
`define OTC_CTRL_RESET 8'h00

// ==========================================================
// decode constants
`define OTC_ANA_ZERO_CODE 7'sh20
`define OTC_DIG_PLUS 2'h1
`define OTC_DIG_ZERO 2'h2
`define OTC_DIG_MINUS 2'h3
`define OTC_DIG_HALF_PPM 8'sh3D

// ==========================================================
// timing
`define OTC_CLK_PERIOD_NS 8
`define OTC_CONV_TIME_NS 22_000_000
`define OTC_CONV_CYCLES (`OTC_CONV_TIME_NS / `OTC_CLK_PERIOD_NS)
`define OTC_BATT_SLOW_S 10'h258
`define OTC_BATT_FAST_S 10'h03C

`endif

/* otc_pkg.sv */
package otc_pkg;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } otc_reg_req_s;

   typedef struct packed {
      logic [1:0] digital;
      logic [5:0] analog;
   } otc_trim_s;

   typedef enum logic [1:0] {
      OTC_IDLE,
      OTC_FIRST,
      OTC_SECOND
   } otc_conv_state_e;

endpackage

/* otc_conv_timer.sv */
`include "otc_defs.svh"

module otc_conv_timer #(
   parameter int unsigned CYCLES = `OTC_CONV_CYCLES
) (
   input wire logic core_clk, // system clock
   input wire logic rst_b, // sync reset, low
   input wire logic ce, // clock enable
   input wire logic start, // begin timing
   input wire logic abort, // stop timing
   output logic halfTick_r, // mid-sequence pulse
   output logic doneTick_r // end-of-sequence pulse
);

   initial begin
      if (CYCLES < 4) $error("otc_conv_timer: CYCLES too small");
   end

   logic [31:0] cnt_r;
   logic run_r;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt_r <= 32'h0000_0000;
         run_r <= 1'b0;
         halfTick_r <= 1'b0;
         doneTick_r <= 1'b0;
      end else if (ce) begin
         halfTick_r <= 1'b0;
         doneTick_r <= 1'b0;
         if (abort) begin
            run_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
         end else if (start) begin
            run_r <= 1'b1;
            cnt_r <= 32'h0000_0000;
         end else if (run_r) begin
            cnt_r <= cnt_r + 32'h0000_0001;
            halfTick_r <= (cnt_r == 32'(CYCLES / 2 - 2));
            if (cnt_r == 32'(CYCLES - 2)) begin
               doneTick_r <= 1'b1;
               run_r <= 1'b0;
            end
         end
      end
   end

endmodule // otc_conv_timer

/* otc_trim_ctrl.sv */
`include "otc_defs.svh"

// Overview of operation
// R1: analog trim spans +32 to -31 ppm in one ppm steps
// R2: analog adjustment equals 32 minus the six-bit code
// R3: trim register at 0Bh: digital trim bits 7:6, analog 5:0
// R4: host changes trims, coefficient, gain only with sensing off
// R5: host avoids lowest analog codes or restarts frequency output
// R6: cold coefficient register at 0Ch, bit 7 ignored
// R7: host encodes coefficient as magnitude times 2048
// R8: host programs both cold and hot coefficients
// R9: control bit 7 enables sensing, conversion and trim adjustment; here the trims always come straight from the trim register
// R10: sensing enable clears at reset
// R11: sensing off means initial trims drive the oscillator
// R12: enabling sensing uses the newly loaded values
// R13: enabling starts two conversions, averaged into the result
// R14: sequence takes 22 ms from the enabling write
// R15: control bit 6 enables sensing in battery mode, default off
// R16: battery below 2.7 V forces battery sensing off
// R17: control bit 5 picks ten-minute or one-minute battery interval
// R18: digital trim 00 off, 01 +30.5, 10 zero, 11 -30.5 ppm
// R19: host writes gain with sensing off, then same with it on
module otc_trim_ctrl #(
   parameter int unsigned CONV_CYCLES = `OTC_CONV_CYCLES,
   parameter int unsigned TEMP_W = 10
) (
   input wire logic core_clk, // system clock
   input wire logic rst_b, // sync reset, low
   input wire logic ce, // clock enable
   input wire otc_pkg::otc_reg_req_s regReq, // register access
   output logic [7:0] regRdData_r, // register read data
   input wire logic onBattery, // running from backup
   input wire logic batteryLow, // backup below 2.7 V
   input wire logic secTick, // one pulse per second
   input wire logic [TEMP_W-1:0] tempSample, // sensor reading
   output otc_pkg::otc_trim_s trimOut_r, // trims to oscillator
   output logic signed [6:0] analogPpm_r, // analog ppm
   output logic signed [7:0] digitalHalfPpm_r, // digital half-ppm
   output logic [6:0] coldCoefOut_r, // coefficient in use
   output logic [4:0] gainOut_r, // gain in use
   output logic compActive_r, // compensation running
   output logic convBusy_r, // conversion in progress
   output logic [TEMP_W-1:0] tempResult_r // averaged temperature
);

   initial begin
      if (TEMP_W < 2 || TEMP_W > 16) $error("otc_trim_ctrl: TEMP_W");
      if (CONV_CYCLES < 4) $error("otc_trim_ctrl: CONV_CYCLES");
   end

   // ========================================================
   // functions
   function automatic logic signed [6:0] anaPpm(input logic [5:0] c);
      anaPpm = `OTC_ANA_ZERO_CODE - $signed({1'b0, c});
   endfunction

   function automatic logic signed [7:0] digPpm(input logic [1:0] c);
      unique case (c)
         `OTC_DIG_PLUS: digPpm = `OTC_DIG_HALF_PPM;
         `OTC_DIG_MINUS: digPpm = -`OTC_DIG_HALF_PPM;
         default: digPpm = 8'sh00;
      endcase
   endfunction

   function automatic logic [TEMP_W-1:0] avg2(input logic [TEMP_W-1:0] a,
                                              input logic [TEMP_W-1:0] b);
      logic [TEMP_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      avg2 = s[TEMP_W:1];
   endfunction

   // ========================================================
   // registers
   otc_pkg::otc_trim_s trimReg_r;
   logic [7:0] coefReg_r;
   logic [7:0] ctrlReg_r;
   logic wrTrim, wrCoef, wrCtrl, senseEn, battEn, battRate, senseRise;

   assign wrTrim = regReq.wrEn && regReq.addr == `OTC_ADDR_TRIM;
   assign wrCoef = regReq.wrEn && regReq.addr == `OTC_ADDR_COEF;
   assign wrCtrl = regReq.wrEn && regReq.addr == `OTC_ADDR_CTRL;
   assign senseEn = ctrlReg_r[`OTC_CTRL_SENSE];
   assign battEn = ctrlReg_r[`OTC_CTRL_BATT_EN];
   assign battRate = ctrlReg_r[`OTC_CTRL_BATT_RATE];
   assign senseRise = wrCtrl && regReq.wrData[`OTC_CTRL_SENSE] && !senseEn;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         trimReg_r <= `OTC_TRIM_RESET;
         coefReg_r <= `OTC_COEF_RESET;
         ctrlReg_r <= `OTC_CTRL_RESET; // R10 R15 R17
      end else if (ce) begin
         if (wrTrim) trimReg_r <= regReq.wrData; // R3
         if (wrCoef) coefReg_r <= {1'b0, regReq.wrData[`OTC_COEF_MSB:0]}; // R6
         if (wrCtrl) ctrlReg_r <= regReq.wrData; // R9
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         regRdData_r <= 8'h00;
      end else if (ce && regReq.rdEn) begin
         unique case (regReq.addr)
            `OTC_ADDR_TRIM: regRdData_r <= trimReg_r;
            `OTC_ADDR_COEF: regRdData_r <= coefReg_r;
            `OTC_ADDR_CTRL: regRdData_r <= ctrlReg_r;
            default: regRdData_r <= 8'h00;
         endcase
      end
   end

   // ========================================================
   // battery-mode interval
   logic battAllowed, battTrig, vddAllowed, active;
   logic [9:0] battSecCnt_r;
   logic [9:0] battPeriod;

   assign battAllowed = onBattery && battEn && !batteryLow; // R16
   assign vddAllowed = !onBattery;
   assign active = senseEn && (vddAllowed || battAllowed); // R15
   assign battPeriod = battRate ? `OTC_BATT_FAST_S : `OTC_BATT_SLOW_S; // R17
   assign battTrig = battAllowed && senseEn && secTick &&
                     battSecCnt_r == battPeriod - 10'h001;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         battSecCnt_r <= 10'h000;
      end else if (ce) begin
         // a rate change restarts the interval
         if (!battAllowed || !senseEn || wrCtrl || battTrig)
            battSecCnt_r <= 10'h000;
         else if (secTick) battSecCnt_r <= battSecCnt_r + 10'h001; // R17
      end
   end

   // ========================================================
   // conversion sequence
   otc_pkg::otc_conv_state_e state_r;
   logic [TEMP_W-1:0] sample0_r;
   logic convStart, convAbort, halfTick, doneTick, wrAllowed;

   // enabling write judged by the value being written
   assign wrAllowed = !onBattery ||
                      (regReq.wrData[`OTC_CTRL_BATT_EN] && !batteryLow);
   assign convStart = ce && state_r == otc_pkg::OTC_IDLE &&
                      ((senseRise && wrAllowed) || battTrig); // R13
   assign convAbort = state_r != otc_pkg::OTC_IDLE && !active;

   otc_conv_timer #(
      .CYCLES(CONV_CYCLES)
   ) u_timer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .start(convStart),
      .abort(convAbort),
      .halfTick_r(halfTick),
      .doneTick_r(doneTick)
   ); // R14

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_r <= otc_pkg::OTC_IDLE;
         sample0_r <= '0;
         tempResult_r <= '0;
      end else if (ce) begin
         unique case (state_r)
            otc_pkg::OTC_IDLE: begin
               if (convStart) state_r <= otc_pkg::OTC_FIRST;
            end
            otc_pkg::OTC_FIRST: begin
               if (convAbort) state_r <= otc_pkg::OTC_IDLE;
               else if (halfTick) begin
                  sample0_r <= tempSample;
                  state_r <= otc_pkg::OTC_SECOND;
               end
            end
            otc_pkg::OTC_SECOND: begin
               if (convAbort) state_r <= otc_pkg::OTC_IDLE;
               else if (doneTick) begin
                  tempResult_r <= avg2(sample0_r, tempSample); // R13
                  state_r <= otc_pkg::OTC_IDLE;
               end
            end
            default: state_r <= otc_pkg::OTC_IDLE;
         endcase
      end
   end

   // ========================================================
   // trim outputs
   otc_pkg::otc_trim_s trimNxt;
   assign trimNxt = trimReg_r; // R11 R12

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         trimOut_r <= `OTC_TRIM_RESET;
         analogPpm_r <= `OTC_ANA_ZERO_CODE;
         digitalHalfPpm_r <= 8'sh00;
         coldCoefOut_r <= 7'h00;
         gainOut_r <= 5'h00;
         compActive_r <= 1'b0;
         convBusy_r <= 1'b0;
      end else if (ce) begin
         trimOut_r <= trimNxt; // R11
         analogPpm_r <= anaPpm(trimNxt.analog); // R1 R2
         digitalHalfPpm_r <= digPpm(trimNxt.digital); // R18
         if (convStart) begin
            coldCoefOut_r <= coefReg_r[`OTC_COEF_MSB:0]; // R12
            gainOut_r <= ctrlReg_r[`OTC_CTRL_GAIN_MSB:0];
         end
         compActive_r <= active; // R9 R16
         convBusy_r <= convStart || (state_r != otc_pkg::OTC_IDLE &&
                       !convAbort && !(state_r == otc_pkg::OTC_SECOND &&
                       doneTick));
      end
   end

   // ========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_analog_decode: assert property (
      analogPpm_r == `OTC_ANA_ZERO_CODE - $signed({1'b0, trimOut_r.analog}))
      else $error("analog ppm mismatch"); // R2
   a_ppm_range: assert property (
      analogPpm_r <= 7'sd32 && analogPpm_r >= -7'sd31)
      else $error("analog ppm out of range"); // R1
   a_trim_write: assert property (ce && wrTrim |=>
      trimReg_r == $past(regReq.wrData))
      else $error("trim write lost"); // R3
   a_coef_bit7: assert property (coefReg_r[7] == 1'b0)
      else $error("coefficient bit 7 stored"); // R6
   a_sense_reset: assert property (!$past(rst_b) |-> !senseEn)
      else $error("sense enable not cleared"); // R10
   a_direct_trim: assert property (ce |=> trimOut_r == $past(trimReg_r))
      else $error("trim output not from register"); // R11
   a_conv_start: assert property (ce && senseRise && !onBattery &&
      state_r == otc_pkg::OTC_IDLE |=> convBusy_r &&
      state_r == otc_pkg::OTC_FIRST)
      else $error("conversion did not start"); // R13
   a_conv_avg: assert property (ce && state_r == otc_pkg::OTC_SECOND &&
      doneTick && !convAbort |=>
      tempResult_r == avg2($past(sample0_r), $past(tempSample)))
      else $error("average wrong"); // R13
   a_batt_low: assert property (ce && onBattery && (batteryLow || !battEn)
      |=> !compActive_r)
      else $error("battery compensation not blocked"); // R15 R16
   a_batt_count: assert property (battSecCnt_r < battPeriod)
      else $error("battery interval overrun"); // R17
   a_dig_decode: assert property (ce && trimReg_r.digital ==
      `OTC_DIG_MINUS |=> digitalHalfPpm_r == -`OTC_DIG_HALF_PPM)
      else $error("digital decode wrong"); // R18

   c_conv_done: cover property (state_r == otc_pkg::OTC_SECOND && doneTick);
   c_batt_trig: cover property (battTrig && convStart);
   c_abort: cover property (convAbort);

endmodule // otc_trim_ctrl

/* otc_trim_ctrl_tb.sv */
`define CHK(NAME, EXP, GOT) begin nCompared++; if ((GOT) !== (EXP)) begin \
   errors++; $display("Error %s expected %h seen %h", NAME, EXP, GOT); end end

module otc_trim_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned CONV = 16;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   otc_pkg::otc_reg_req_s regReq = '0;
   logic onBattery = 1'b0;
   logic batteryLow = 1'b0;
   logic secTick = 1'b0;
   logic [9:0] tempSample = 10'h2A5;
   otc_pkg::otc_trim_s trimOut_r;
   logic [7:0] regRdData_r;
   logic signed [6:0] analogPpm_r;
   logic signed [7:0] digitalHalfPpm_r;
   logic [6:0] coldCoefOut_r;
   logic [4:0] gainOut_r;
   logic compActive_r;
   logic convBusy_r;
   logic [9:0] tempResult_r;
   logic [7:0] dexp [4] = '{8'h00, 8'h3D, 8'h00, 8'hC3};
   int errors = 0;
   int nCompared = 0;
   int cycles = 0;
   int n;

   otc_trim_ctrl #(.CONV_CYCLES(CONV), .TEMP_W(10)) u_dut (
      .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .regReq(regReq),
      .regRdData_r(regRdData_r), .onBattery(onBattery),
      .batteryLow(batteryLow), .secTick(secTick), .tempSample(tempSample),
      .trimOut_r(trimOut_r), .analogPpm_r(analogPpm_r),
      .digitalHalfPpm_r(digitalHalfPpm_r), .coldCoefOut_r(coldCoefOut_r),
      .gainOut_r(gainOut_r), .compActive_r(compActive_r),
      .convBusy_r(convBusy_r), .tempResult_r(tempResult_r)
   );

   always #4 core_clk = ~core_clk;

   // ==========================================
   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         tally_and_finish();
      end
   end

   // ==========================================
   // access tasks
   task automatic step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step(1);
      regReq.wrEn = 1'b1;
      regReq.addr = a;
      regReq.wrData = d;
      step(1);
      regReq.wrEn = 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      step(1);
      regReq.rdEn = 1'b1;
      regReq.addr = a;
      step(1);
      regReq.rdEn = 1'b0;
      `CHK("readData", e, regRdData_r)
   endtask

   task automatic ticks(input int k);
      repeat (k) begin
         step(1);
         secTick = 1'b1;
         step(1);
         secTick = 1'b0;
      end
   endtask

   task automatic waitDone(output int k);
      k = 0;
      while (convBusy_r !== 1'b0 && k < 200) begin
         step(1);
         k++;
      end
      `CHK("convEnd", 1'b0, convBusy_r)
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================
   // tests
   initial begin
      step(16);
      rst_b = 1'b1;
      rdchk(8'h0B, 8'h00);
      rdchk(8'h0D, 8'h00);
      `CHK("analogPpm", 7'h20, analogPpm_r)
      `CHK("compActive", 1'b0, compActive_r)
      `CHK("convBusy", 1'b0, convBusy_r)
      $display("test reset done");
      for (int i = 0; i < 64; i++) begin
         wr(8'h0B, {i[1:0], i[5:0]});
         step(1);
         `CHK("trimOut", {i[1:0], i[5:0]}, trimOut_r)
         `CHK("analogPpm", 7'(32 - i), analogPpm_r)
         `CHK("digPpm", dexp[i[1:0]], digitalHalfPpm_r)
         rdchk(8'h0B, {i[1:0], i[5:0]});
      end
      $display("test trim decode done");
      wr(8'h0C, 8'hFF);
      rdchk(8'h0C, 8'h7F);
      wr(8'h0E, 8'h5A);
      rdchk(8'h0E, 8'h00);
      wr(8'h0B, 8'hA0);
      wr(8'h0C, 8'h46);
      wr(8'h0D, 8'h15);
      step(2);
      `CHK("trimOut", 8'hA0, trimOut_r)
      `CHK("compActive", 1'b0, compActive_r)
      `CHK("convBusy", 1'b0, convBusy_r)
      $display("test map done");
      wr(8'h0D, 8'h95);
      step(1);
      `CHK("convBusy", 1'b1, convBusy_r)
      `CHK("compActive", 1'b1, compActive_r)
      step(10);
      tempSample = 10'h1A4;
      waitDone(n);
      `CHK("convLen", n + 11 >= CONV - 4 && n + 11 <= CONV + 4, 1'b1)
      `CHK("tempResult", 10'h224, tempResult_r)
      `CHK("coldCoef", 7'h46, coldCoefOut_r)
      `CHK("gain", 5'h15, gainOut_r)
      $display("test conversion done");
      onBattery = 1'b1;
      wr(8'h0D, 8'hB5);
      step(2);
      `CHK("compActive", 1'b0, compActive_r)
      ticks(70);
      `CHK("convBusy", 1'b0, convBusy_r)
      wr(8'h0D, 8'hF5);
      step(2);
      `CHK("compActive", 1'b1, compActive_r)
      ticks(59);
      `CHK("convBusy", 1'b0, convBusy_r)
      ticks(1);
      step(2);
      `CHK("convBusy", 1'b1, convBusy_r)
      waitDone(n);
      batteryLow = 1'b1;
      step(2);
      `CHK("compActive", 1'b0, compActive_r)
      ticks(70);
      `CHK("convBusy", 1'b0, convBusy_r)
      batteryLow = 1'b0;
      wr(8'h0D, 8'hD5);
      ticks(599);
      `CHK("convBusy", 1'b0, convBusy_r)
      ticks(1);
      step(2);
      `CHK("convBusy", 1'b1, convBusy_r)
      waitDone(n);
      $display("test battery done");
      wr(8'h0D, 8'h55);
      wr(8'h0D, 8'hD5);
      step(2);
      `CHK("convBusy", 1'b1, convBusy_r)
      batteryLow = 1'b1;
      step(2);
      `CHK("convBusy", 1'b0, convBusy_r)
      `CHK("tempResult", 10'h1A4, tempResult_r)
      wr(8'h0D, 8'h55);
      ce = 1'b0;
      wr(8'h0B, 8'h55);
      ce = 1'b1;
      rdchk(8'h0B, 8'hA0);
      `CHK("trimOut", 8'hA0, trimOut_r)
      $display("test abort and hold done");
      tally_and_finish();
   end
endmodule // otc_trim_ctrl_tb
